// ---- logic/atwmc_pkg.sv ----
/*
  Shared constants and types for the converter trigger, window and input-select control.
  Assumes one 50 MHz clock domain and an 8-bit special function register port.
*/
`default_nettype none

package atwmc_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_CTRL = 8'hE8;
  localparam logic [7:0] ADDR_CFG = 8'hBC;
  localparam logic [7:0] ADDR_RES_H = 8'hBE;
  localparam logic [7:0] ADDR_RES_L = 8'hBD;
  localparam logic [7:0] ADDR_UL_L = 8'hC3;
  localparam logic [7:0] ADDR_UL_H = 8'hC4;
  localparam logic [7:0] ADDR_LL_L = 8'hC5;
  localparam logic [7:0] ADDR_LL_H = 8'hC6;
  localparam logic [7:0] ADDR_NEG = 8'hBA;
  localparam logic [7:0] ADDR_POS = 8'hBB;

  // Control register bit positions
  localparam int CTRL_EN = 7;
  localparam int CTRL_TM = 6;
  localparam int CTRL_CINT = 5;
  localparam int CTRL_BUSY = 4;
  localparam int CTRL_WINT = 3;
  localparam int CTRL_CM_HI = 2;
  localparam int CTRL_CM_LO = 0;

  // Configuration register fields
  localparam int CFG_DIV_HI = 7;
  localparam int CFG_DIV_LO = 3;
  localparam int CFG_JUST = 2;

  // Reset values
  localparam logic [7:0] CFG_RST = 8'hF8;
  localparam logic [15:0] UL_RST = 16'hFFFF;
  localparam logic [15:0] LL_RST = 16'h0000;
  localparam logic [4:0] MUX_RST = 5'h1F;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Start-of-conversion source codes
  localparam logic [2:0] TRIG_SW = 3'h0;
  localparam logic [2:0] TRIG_T0 = 3'h1;
  localparam logic [2:0] TRIG_T2 = 3'h2;
  localparam logic [2:0] TRIG_T1 = 3'h3;
  localparam logic [2:0] TRIG_PIN = 3'h4;
  localparam logic [2:0] TRIG_T3A = 3'h5;
  localparam logic [2:0] TRIG_T3B = 3'h6;
  localparam logic [2:0] TRIG_T5 = 3'h7;

  // Multiplexer codes
  localparam logic [4:0] NEG_GND = 5'h11;
  localparam logic [4:0] MUX_LAST_VALID = 5'h15;

  // Result layout
  localparam int RES_W = 10;
  localparam int PAD_W = 6;

  // Extra tracking in delayed track mode, in converter clocks
  localparam logic [1:0] TRACK_CLKS = 2'h3;
  localparam logic [1:0] TRACK_LAST = 2'h1;
  localparam logic [4:0] DIV_ZERO = 5'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TRACK = 3'b010,
    ST_CONV = 3'b100
  } atwmc_fsm_t;

  typedef struct packed {
    logic t0;
    logic t1;
    logic t2;
    logic t3;
    logic t5;
  } atwmc_timer_ovf_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } atwmc_sfr_req_t;

  typedef struct packed {
    logic start;
    logic enable;
    logic sar_clk_en;
    logic single_ended;
    logic pos_connected;
    logic neg_connected;
    logic [4:0] pos_sel;
    logic [4:0] neg_sel;
  } atwmc_conv_ctrl_t;

  typedef struct packed {
    atwmc_fsm_t fsm;
    atwmc_conv_ctrl_t conv;
    logic en;
    logic tm;
    logic cint;
    logic busy;
    logic wint;
    logic [2:0] cm;
    logic [7:0] cfg;
    logic [15:0] ul;
    logic [15:0] ll;
    logic [RES_W-1:0] result;
    logic [4:0] div_cnt;
    logic [1:0] track_cnt;
    logic [1:0] pin_sync;
    logic pin_prev;
    logic [7:0] rdata;
  } atwmc_state_t;

endpackage : atwmc_pkg

`default_nettype wire

// ---- logic/atwmc_top.sv ----
/*
  Control logic around a 10-bit successive-approximation converter: trigger source
  selection, delayed tracking, result justification, window comparison, input select.
  Assumes the analog core takes a one-cycle start and returns a one-cycle done with data,
  both on i_clk; timer overflows are i_clk pulses; the convert-start pin is asynchronous.
*/
`default_nettype none

module atwmc_top (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire atwmc_pkg::atwmc_sfr_req_t i_sfr,
  input wire atwmc_pkg::atwmc_timer_ovf_t i_timer_ovf,
  input wire logic i_external_convert_start_pin,
  input wire logic i_conv_done,
  input wire logic [atwmc_pkg::RES_W-1:0] i_conv_data,
  output atwmc_pkg::atwmc_conv_ctrl_t o_conv,
  output logic [7:0] o_sfr_rdata,
  output logic o_window_match_flag,
  output logic o_conv_complete_flag
);

  atwmc_pkg::atwmc_state_t state_reg;
  atwmc_pkg::atwmc_state_t state_next;

  // Codes above the last pin code leave the multiplexer input open
  function automatic logic input_connected(input logic [4:0] code);
    input_connected = (code <= atwmc_pkg::MUX_LAST_VALID);
  endfunction : input_connected

  // Places a 10-bit result in a 16-bit word per the justify bit
  function automatic logic [15:0] justify(input logic [atwmc_pkg::RES_W-1:0] res,
                                          input logic left);
    if (left) begin
      justify = {res, {atwmc_pkg::PAD_W{1'b0}}};
    end else begin
      justify = {{atwmc_pkg::PAD_W{1'b0}}, res};
    end
  endfunction : justify

  logic trig_hit;
  logic pin_edge;
  logic start_req;
  logic sw_ctrl_wr;
  logic [15:0] res_word;
  logic [15:0] view_word;
  logic window_hit;
  logic track_delay;

  always_comb begin
    state_next = state_reg;
    state_next.conv.start = 1'b0;

    // Convert-start pin: two-stage synchroniser, then edge from the second stage
    state_next.pin_sync = {state_reg.pin_sync[0], i_external_convert_start_pin};
    state_next.pin_prev = state_reg.pin_sync[1];
    pin_edge = state_reg.pin_sync[1] & ~state_reg.pin_prev;

    // Converter clock enable divider
    if (state_reg.div_cnt == atwmc_pkg::DIV_ZERO) begin
      state_next.div_cnt = state_reg.cfg[atwmc_pkg::CFG_DIV_HI:atwmc_pkg::CFG_DIV_LO];
      state_next.conv.sar_clk_en = 1'b1;
    end else begin
      state_next.div_cnt = state_reg.div_cnt - 5'h01;
      state_next.conv.sar_clk_en = 1'b0;
    end

    sw_ctrl_wr = i_sfr.wr && (i_sfr.addr == atwmc_pkg::ADDR_CTRL);

    case (state_reg.cm)
      atwmc_pkg::TRIG_SW: trig_hit = sw_ctrl_wr && i_sfr.wdata[atwmc_pkg::CTRL_BUSY];
      atwmc_pkg::TRIG_T0: trig_hit = i_timer_ovf.t0;
      atwmc_pkg::TRIG_T2: trig_hit = i_timer_ovf.t2;
      atwmc_pkg::TRIG_T1: trig_hit = i_timer_ovf.t1;
      atwmc_pkg::TRIG_PIN: trig_hit = pin_edge;
      atwmc_pkg::TRIG_T3A: trig_hit = i_timer_ovf.t3;
      atwmc_pkg::TRIG_T3B: trig_hit = i_timer_ovf.t3;
      atwmc_pkg::TRIG_T5: trig_hit = i_timer_ovf.t5;
      default: trig_hit = 1'b0;
    endcase

    // Triggers are dropped while disabled or while a conversion is under way
    start_req = trig_hit && state_reg.en && (state_reg.fsm == atwmc_pkg::ST_IDLE);
    track_delay = state_reg.tm && (state_reg.cm != atwmc_pkg::TRIG_PIN);

    // Window check on the finished word, using the justification in force now
    res_word = justify(i_conv_data, state_reg.cfg[atwmc_pkg::CFG_JUST]);
    if (state_reg.ll > state_reg.ul) begin
      window_hit = (res_word > state_reg.ul) && (res_word < state_reg.ll);
    end else begin
      window_hit = (res_word > state_reg.ul) || (res_word < state_reg.ll);
    end

    // Software writes
    if (i_sfr.wr) begin
      case (i_sfr.addr)
        atwmc_pkg::ADDR_CTRL: begin
          state_next.en = i_sfr.wdata[atwmc_pkg::CTRL_EN];
          state_next.tm = i_sfr.wdata[atwmc_pkg::CTRL_TM];
          state_next.cint = i_sfr.wdata[atwmc_pkg::CTRL_CINT];
          state_next.wint = i_sfr.wdata[atwmc_pkg::CTRL_WINT];
          state_next.cm = i_sfr.wdata[atwmc_pkg::CTRL_CM_HI:atwmc_pkg::CTRL_CM_LO];
        end
        atwmc_pkg::ADDR_CFG: state_next.cfg = i_sfr.wdata;
        atwmc_pkg::ADDR_UL_L: state_next.ul[7:0] = i_sfr.wdata;
        atwmc_pkg::ADDR_UL_H: state_next.ul[15:8] = i_sfr.wdata;
        atwmc_pkg::ADDR_LL_L: state_next.ll[7:0] = i_sfr.wdata;
        atwmc_pkg::ADDR_LL_H: state_next.ll[15:8] = i_sfr.wdata;
        atwmc_pkg::ADDR_POS: state_next.conv.pos_sel = i_sfr.wdata[4:0];
        atwmc_pkg::ADDR_NEG: state_next.conv.neg_sel = i_sfr.wdata[4:0];
        default: begin
        end
      endcase
    end

    // Conversion sequencing; hardware sets below override a same-cycle software clear
    case (state_reg.fsm)
      atwmc_pkg::ST_IDLE: begin
        if (start_req) begin
          state_next.busy = 1'b1;
          if (track_delay) begin
            state_next.track_cnt = atwmc_pkg::TRACK_CLKS;
            state_next.fsm = atwmc_pkg::ST_TRACK;
          end else begin
            state_next.conv.start = 1'b1;
            state_next.fsm = atwmc_pkg::ST_CONV;
          end
        end
      end
      atwmc_pkg::ST_TRACK: begin
        if (state_reg.conv.sar_clk_en) begin
          if (state_reg.track_cnt == atwmc_pkg::TRACK_LAST) begin
            state_next.conv.start = 1'b1;
            state_next.fsm = atwmc_pkg::ST_CONV;
          end else begin
            state_next.track_cnt = state_reg.track_cnt - 2'h1;
          end
        end
      end
      atwmc_pkg::ST_CONV: begin
        if (i_conv_done) begin
          state_next.result = i_conv_data;
          state_next.busy = 1'b0;
          state_next.cint = 1'b1;
          if (window_hit) begin
            state_next.wint = 1'b1;
          end
          state_next.fsm = atwmc_pkg::ST_IDLE;
        end
      end
      default: state_next.fsm = atwmc_pkg::ST_IDLE;
    endcase

    // Converter-side copy of the enable bit and decode of the multiplexer settings
    state_next.conv.enable = state_next.en;
    state_next.conv.single_ended = (state_next.conv.neg_sel == atwmc_pkg::NEG_GND);
    state_next.conv.pos_connected = input_connected(state_next.conv.pos_sel);
    state_next.conv.neg_connected = input_connected(state_next.conv.neg_sel);

    // Read data is registered: valid the cycle after the read strobe
    view_word = justify(state_reg.result, state_reg.cfg[atwmc_pkg::CFG_JUST]);
    if (i_sfr.rd) begin
      case (i_sfr.addr)
        atwmc_pkg::ADDR_CTRL: state_next.rdata = {state_reg.en, state_reg.tm, state_reg.cint,
                                                  state_reg.busy, state_reg.wint,
                                                  state_reg.cm};
        atwmc_pkg::ADDR_CFG: state_next.rdata = state_reg.cfg;
        atwmc_pkg::ADDR_RES_H: state_next.rdata = view_word[15:8];
        atwmc_pkg::ADDR_RES_L: state_next.rdata = view_word[7:0];
        atwmc_pkg::ADDR_UL_L: state_next.rdata = state_reg.ul[7:0];
        atwmc_pkg::ADDR_UL_H: state_next.rdata = state_reg.ul[15:8];
        atwmc_pkg::ADDR_LL_L: state_next.rdata = state_reg.ll[7:0];
        atwmc_pkg::ADDR_LL_H: state_next.rdata = state_reg.ll[15:8];
        atwmc_pkg::ADDR_POS: state_next.rdata = {3'h0, state_reg.conv.pos_sel};
        atwmc_pkg::ADDR_NEG: state_next.rdata = {3'h0, state_reg.conv.neg_sel};
        default: state_next.rdata = atwmc_pkg::BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg.fsm <= atwmc_pkg::ST_IDLE;
      state_reg.conv.start <= 1'b0;
      state_reg.conv.enable <= 1'b0;
      state_reg.conv.sar_clk_en <= 1'b0;
      state_reg.conv.single_ended <= 1'b0;
      state_reg.conv.pos_connected <= 1'b0;
      state_reg.conv.neg_connected <= 1'b0;
      state_reg.conv.pos_sel <= atwmc_pkg::MUX_RST;
      state_reg.conv.neg_sel <= atwmc_pkg::MUX_RST;
      state_reg.en <= 1'b0;
      state_reg.tm <= 1'b0;
      state_reg.cint <= 1'b0;
      state_reg.busy <= 1'b0;
      state_reg.wint <= 1'b0;
      state_reg.cm <= atwmc_pkg::TRIG_SW;
      state_reg.cfg <= atwmc_pkg::CFG_RST;
      state_reg.ul <= atwmc_pkg::UL_RST;
      state_reg.ll <= atwmc_pkg::LL_RST;
      state_reg.result <= '0;
      state_reg.div_cnt <= atwmc_pkg::DIV_ZERO;
      state_reg.track_cnt <= 2'h0;
      state_reg.pin_sync <= 2'h0;
      state_reg.pin_prev <= 1'b0;
      state_reg.rdata <= atwmc_pkg::BYTE_ZERO;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_conv = state_reg.conv;
  assign o_sfr_rdata = state_reg.rdata;
  assign o_window_match_flag = state_reg.wint;
  assign o_conv_complete_flag = state_reg.cint;

endmodule : atwmc_top

`default_nettype wire

// ---- sim/atwmc_chk.sv ----
/*
  Port-level concurrent checks for atwmc_top.
  Assumes atwmc_pkg is compiled first; bound to every atwmc_top instance.
*/
`default_nettype none

module atwmc_chk (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire atwmc_pkg::atwmc_sfr_req_t i_sfr,
  input wire atwmc_pkg::atwmc_conv_ctrl_t o_conv,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_conv_done,
  input wire logic o_window_match_flag
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  logic ctrl_wr;
  logic mux_rd;
  assign ctrl_wr = i_sfr.wr && (i_sfr.addr == atwmc_pkg::ADDR_CTRL);
  assign mux_rd = i_sfr.rd &&
    (i_sfr.addr == atwmc_pkg::ADDR_NEG || i_sfr.addr == atwmc_pkg::ADDR_POS);
  chk_start_pulse: assert property (o_conv.start |=> !o_conv.start)
    else $error("start held longer than one cycle");
  chk_start_enabled: assert property (o_conv.start |-> o_conv.enable)
    else $error("start while disabled");
  chk_flag_sticky: assert property ($fell(o_window_match_flag) |->
    $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("window flag dropped without a control write");
  chk_flag_cause: assert property ($rose(o_window_match_flag) |-> $past(i_conv_done)
    || $past(i_conv_done, 2) || $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("window flag rose without a result");
  chk_single_ended: assert property (o_conv.single_ended ==
    (o_conv.neg_sel == atwmc_pkg::NEG_GND))
    else $error("single-ended decode wrong");
  chk_neg_conn: assert property (o_conv.neg_connected ==
    (o_conv.neg_sel <= atwmc_pkg::MUX_LAST_VALID))
    else $error("negative connect decode wrong");
  chk_pos_conn: assert property (o_conv.pos_connected ==
    (o_conv.pos_sel <= atwmc_pkg::MUX_LAST_VALID))
    else $error("positive connect decode wrong");
  chk_mux_read: assert property (mux_rd |=> o_sfr_rdata[7:5] == 3'h0)
    else $error("mux select upper bits not zero");
  chk_null_read: assert property (i_sfr.rd && i_sfr.addr == 8'h00 |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!i_sfr.rd |=> $stable(o_sfr_rdata))
    else $error("read data moved without a read");
endmodule : atwmc_chk

bind atwmc_top atwmc_chk chk_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_sfr(i_sfr), .o_conv(o_conv),
  .o_sfr_rdata(o_sfr_rdata), .i_conv_done(i_conv_done), .o_window_match_flag(o_window_match_flag));

`default_nettype wire

// ---- sim/test_atwmc_top.sv ----
/*
  Self-checking bench for atwmc_top: reset values, trigger sources, window and mux select.
  Assumes atwmc_pkg and the design are compiled first.
*/
`default_nettype none

module test_atwmc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_nrst, pin, done, tm, just, hit;
  atwmc_pkg::atwmc_sfr_req_t sfr;
  atwmc_pkg::atwmc_timer_ovf_t tov;
  atwmc_pkg::atwmc_conv_ctrl_t conv;
  logic [9:0] cdat, d;
  logic [7:0] rdata, rv, c;
  logic [15:0] ul, ll, r16;
  logic [2:0] code;
  logic wflag, cflag;
  int bad_count, tests_run, seed, n, k, starts;
  logic [7:0] ra [11] = '{atwmc_pkg::ADDR_CTRL, atwmc_pkg::ADDR_CFG, atwmc_pkg::ADDR_UL_L,
    atwmc_pkg::ADDR_UL_H, atwmc_pkg::ADDR_LL_L, atwmc_pkg::ADDR_LL_H, atwmc_pkg::ADDR_POS,
    atwmc_pkg::ADDR_NEG, atwmc_pkg::ADDR_RES_H, atwmc_pkg::ADDR_RES_L, 8'h00};
  logic [7:0] rx [11] = '{8'h00, 8'hF8, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h1F, 8'h1F,
    8'h00, 8'h00, 8'h00};
  atwmc_top uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_sfr(sfr), .i_timer_ovf(tov),
    .i_external_convert_start_pin(pin), .i_conv_done(done), .i_conv_data(cdat),
    .o_conv(conv), .o_sfr_rdata(rdata), .o_window_match_flag(wflag),
    .o_conv_complete_flag(cflag));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (conv.start === 1'b1) starts++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_clk);
    sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge i_clk);
    sfr.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge i_clk);
    sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge i_clk);
    sfr.rd = 1'b0;
    v = rdata;
  endtask : rd
  function automatic logic exp_hit(input logic [15:0] r, input logic [15:0] u,
                                   input logic [15:0] l);
    return (l > u) ? (r > u && r < l) : (r > u || r < l);
  endfunction : exp_hit
  // Timer vector order is t0, t1, t2, t3, t5
  function automatic logic [4:0] tvec(input logic [2:0] m);
    case (m)
      3'h1: return 5'h10;
      3'h2: return 5'h04;
      3'h3: return 5'h08;
      3'h5, 3'h6: return 5'h02;
      3'h7: return 5'h01;
      default: return 5'h00;
    endcase
  endfunction : tvec
  initial begin
    #1000000;
    bad_count++;
    final_report();
  end
  initial begin
    {i_nrst, pin, done, cdat, tov, sfr} = '0;
    seed = 32'h0455;
    repeat (16) @(negedge i_clk);
    i_nrst = 1'b1;
    for (int j = 0; j < 11; j++) begin
      rd(ra[j], rv);
      check(rv, rx[j]);
    end
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      code = i[2:0];
      tm = (i >= 12);
      just = (i >= 10) ? $random(seed) : 1'b0;
      ul = $random(seed);
      ll = $random(seed);
      d = $random(seed);
      // Boundary values on the upper limit and one step past a limit, inside then outside layout
      if (i == 0 || i == 1 || i == 8 || i == 9) begin
        ul = (i < 8) ? 16'h0040 : 16'h0080;
        ll = (i < 8) ? 16'h0080 : 16'h0040;
        d = (i == 0) ? 10'h040 : (i == 1) ? 10'h041 : (i == 8) ? 10'h080 : 10'h03F;
      end
      wr(atwmc_pkg::ADDR_UL_L, ul[7:0]);
      wr(atwmc_pkg::ADDR_UL_H, ul[15:8]);
      wr(atwmc_pkg::ADDR_LL_L, ll[7:0]);
      wr(atwmc_pkg::ADDR_LL_H, ll[15:8]);
      wr(atwmc_pkg::ADDR_CFG, {5'h1F, just, 2'h0});
      rd(atwmc_pkg::ADDR_UL_H, rv);
      check(rv, ul[15:8]);
      wr(atwmc_pkg::ADDR_CTRL, {1'b1, tm, 3'h0, code});
      check(conv.enable, 1'b1);
      n = starts;
      tov = ~tvec(code);
      pin = (code != 3'h4);
      @(negedge i_clk);
      tov = 5'h00;
      repeat (8) @(negedge i_clk);
      pin = 1'b0;
      check(starts - n, 0);
      if (code == 3'h0) wr(atwmc_pkg::ADDR_CTRL, {1'b1, tm, 3'h2, code});
      tov = tvec(code);
      pin = (code == 3'h4);
      @(negedge i_clk);
      tov = 5'h00;
      k = 0;
      // A software start pulses during the write itself, so count pulses instead of polling
      while (starts == n && k < 300) begin
        @(negedge i_clk);
        k++;
      end
      if (tm && code != 3'h4) check(k > 40 && k < 300, 1'b1);
      else check(k < 8, 1'b1);
      @(negedge i_clk);
      done = 1'b1;
      cdat = d;
      @(negedge i_clk);
      done = 1'b0;
      cdat = ~d;
      repeat (3) @(negedge i_clk);
      pin = 1'b0;
      r16 = just ? {d, 6'h00} : {6'h00, d};
      hit = exp_hit(r16, ul, ll);
      check(wflag, hit);
      check(cflag, 1'b1);
      rd(atwmc_pkg::ADDR_CTRL, rv);
      check(rv[3], hit);
      rd(atwmc_pkg::ADDR_RES_H, rv);
      check(rv, r16[15:8]);
      rd(atwmc_pkg::ADDR_RES_L, rv);
      check(rv, r16[7:0]);
      wr(atwmc_pkg::ADDR_CTRL, {1'b1, tm, 3'h0, code});
      @(negedge i_clk);
      check({wflag, cflag}, 2'h0);
      $display("trigger test %0d done", i);
    end
    for (int j = 0; j < 8; j++) begin
      c = (j == 0) ? 8'hF1 : (j == 1) ? 8'h16 : (j == 2) ? 8'h15 : $random(seed);
      // Pin mode and crossbar skip live outside this block; selected pins count as analog
      wr(atwmc_pkg::ADDR_NEG, c);
      wr(atwmc_pkg::ADDR_POS, c);
      check({conv.single_ended, conv.neg_connected},
        {c[4:0] == 5'h11, c[4:0] <= 5'h15});
      check({conv.pos_connected, conv.pos_sel}, {c[4:0] <= 5'h15, c[4:0]});
      rd(atwmc_pkg::ADDR_NEG, rv);
      check(rv, {3'h0, c[4:0]});
    end
    $display("mux test done");
    final_report();
  end
endmodule : test_atwmc_top

`default_nettype wire
